/* include/ptr_pkg.sv */
// constants and types for the program table read unit
package ptr_pkg;

   // widths
   localparam int PTR_W     = 21;
   localparam int ADR_W     = 22;
   localparam int BLK_W     = 3;
   localparam int BLK_SHIFT = 14;

   // instruction decode
   localparam logic [15:0] OPC_FIXED = 16'h0008;
   localparam logic [15:0] OPC_MASK  = 16'hFFFC;

   typedef enum logic [1:0] {
      MODE_KEEP    = 2'b00,
      MODE_POSTINC = 2'b01,
      MODE_POSTDEC = 2'b10,
      MODE_PREINC  = 2'b11
   } ptr_mode_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_READ = 1'b1
   } ptr_state_t;

   // register byte addresses
   localparam logic [ADR_W-1:0] ADDR_GUARD_LO = 22'h30000C;
   localparam logic [ADR_W-1:0] ADDR_GUARD_HI = 22'h30000D;
   localparam logic [ADR_W-1:0] ADDR_PTR_L    = 22'h3FFFF0;
   localparam logic [ADR_W-1:0] ADDR_PTR_H    = 22'h3FFFF1;
   localparam logic [ADR_W-1:0] ADDR_PTR_U    = 22'h3FFFF2;
   localparam logic [ADR_W-1:0] ADDR_LATCH    = 22'h3FFFF3;
   localparam logic [ADR_W-1:0] ADDR_STATUS   = 22'h3FFFF4;

   // guard byte layout and unprogrammed values
   localparam logic [7:0] GUARD_LO_MASK  = 8'h3F;
   localparam logic [7:0] GUARD_HI_MASK  = 8'h40;
   localparam logic [7:0] GUARD_LO_RESET = 8'h3F;
   localparam logic [7:0] GUARD_HI_RESET = 8'h40;
   localparam int         BOOT_BIT       = 6;

   // address map of guarded regions
   localparam logic [PTR_W-1:0] BOOT_LAST = 21'h0007FF;
   localparam logic [PTR_W-1:0] BLK_LAST  = 21'h017FFF;
   localparam logic [BLK_W-1:0] BLK_BOOT  = 3'h6;
   localparam logic [BLK_W-1:0] BLK_NONE  = 3'h7;

   // pointer and status layout
   localparam logic [PTR_W-1:0] PTR_ONE     = 21'h000001;
   localparam logic [PTR_W-1:0] PTR_RESET   = 21'h000000;
   localparam logic [7:0]       PTR_U_MASK  = 8'h1F;
   localparam logic [7:0]       LATCH_RESET = 8'h00;
   localparam logic [7:0]       REFUSED_BYTE = 8'h00;
   localparam int               STAT_REFUSED = 0;
   localparam int               STAT_BUSY    = 1;

endpackage : ptr_pkg

/* rtl/ptr_table_read.sv */
// program table read unit: pointer, latch, read guards and register port
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module ptr_table_read (
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          SRST,
   // instruction issue from the core
   input  wire logic                          INSTR_VALID,
   input  wire logic [15:0]                   INSTR_WORD,
   input  wire logic [ptr_pkg::PTR_W-1:0]     INSTR_PC,
   output logic                               INSTR_READY,
   // completion
   output logic                               TBL_DONE,
   output logic                               TBL_REFUSED,
   output logic [7:0]                         TABLE_LATCH,
   output logic [ptr_pkg::PTR_W-1:0]          TABLE_POINTER,
   // program memory array
   output logic [ptr_pkg::PTR_W-1:0]          MEM_ADDR,
   output logic                               MEM_RD,
   input  wire logic [15:0]                   MEM_DATA,
   // register port
   input  wire logic [ptr_pkg::ADR_W-1:0]     REG_ADDR,
   input  wire logic [7:0]                    REG_WDATA,
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   output logic [7:0]                         REG_RDATA
);

   // region number of a byte address: blocks 0..5, boot, or unguarded
   function automatic logic [ptr_pkg::BLK_W-1:0] region_of(
      input logic [ptr_pkg::PTR_W-1:0] addr
   );
      logic [ptr_pkg::BLK_W-1:0] r;
      r = ptr_pkg::BLK_NONE;
      if (addr <= ptr_pkg::BOOT_LAST) begin
         r = ptr_pkg::BLK_BOOT;
      end else if (addr <= ptr_pkg::BLK_LAST) begin
         r = addr[ptr_pkg::BLK_SHIFT +: ptr_pkg::BLK_W];
      end
      return r;
   endfunction : region_of

   // guard bit of a region; unguarded space is always open
   function automatic logic guard_open(
      input logic [ptr_pkg::BLK_W-1:0] reg_n,
      input logic [7:0]                lo,
      input logic [7:0]                hi
   );
      logic g;
      g = 1'b1;
      case (reg_n)
         ptr_pkg::BLK_BOOT: g = hi[ptr_pkg::BOOT_BIT];
         ptr_pkg::BLK_NONE: g = 1'b1;
         default:           g = lo[reg_n];
      endcase
      return g;
   endfunction : guard_open

   // guard byte after a clearing write; a bit can only go from one to zero
   function automatic logic [7:0] guard_clear(
      input logic [7:0] old,
      input logic [7:0] wdata,
      input logic [7:0] mask
   );
      return old & wdata & mask;
   endfunction : guard_clear

   // state
   ptr_pkg::ptr_state_t             state;
   ptr_pkg::ptr_state_t             next_state;
   ptr_pkg::ptr_mode_t              mode;
   logic [ptr_pkg::PTR_W-1:0]       pointer;
   logic [ptr_pkg::PTR_W-1:0]       next_pointer;
   logic [ptr_pkg::PTR_W-1:0]       mem_addr;
   logic [ptr_pkg::BLK_W-1:0]       exec_region;
   logic [7:0]                      latch;
   logic [7:0]                      next_latch;
   logic [7:0]                      guard_lo;
   logic [7:0]                      guard_hi;
   logic                            refused_flag;
   logic                            done;
   logic                            refused;
   logic                            mem_rd;
   logic [7:0]                      rdata;

   // decode wires
   logic                            is_table_read_instr;
   logic                            accept;
   ptr_pkg::ptr_mode_t              instr_mode;
   logic [ptr_pkg::PTR_W-1:0]       ptr_inc;
   logic [ptr_pkg::PTR_W-1:0]       ptr_dec;
   logic [ptr_pkg::PTR_W-1:0]       target;
   logic [ptr_pkg::BLK_W-1:0]       target_region;
   logic                            allowed;
   logic [7:0]                      mem_byte;
   logic                            in_read;

   // register decode wires
   logic                            sel_glo;
   logic                            sel_ghi;
   logic                            sel_pl;
   logic                            sel_ph;
   logic                            sel_pu;
   logic                            sel_lat;
   logic                            sel_stat;
   logic                            wr_ptr;
   logic [ptr_pkg::PTR_W-1:0]       sw_pointer;
   logic [7:0]                      status_byte;
   logic [7:0]                      rd_mux;
   logic                            wr_glo;
   logic                            wr_ghi;
   logic                            wr_lat;
   logic                            clr_refused;
   logic                            refuse_now;
   logic [7:0]                      next_guard_lo;
   logic [7:0]                      next_guard_hi;
   logic [7:0]                      guard_lo_view;
   logic [7:0]                      guard_hi_view;
   logic [7:0]                      ptr_u_view;

   // instruction decode; only the fixed opcode is taken
   assign is_table_read_instr    = (INSTR_WORD & ptr_pkg::OPC_MASK) == ptr_pkg::OPC_FIXED;
   assign instr_mode  = ptr_pkg::ptr_mode_t'(INSTR_WORD[1:0]);
   assign INSTR_READY = (state == ptr_pkg::ST_IDLE);
   assign accept      = INSTR_VALID & is_table_read_instr & INSTR_READY;

   // wrapping arithmetic, a carry out of bit 20 is simply dropped
   assign ptr_inc = pointer + ptr_pkg::PTR_ONE;
   assign ptr_dec = pointer - ptr_pkg::PTR_ONE;

   // pre-increment reads at the bumped address, others at the current one
   assign target = (instr_mode == ptr_pkg::MODE_PREINC) ? ptr_inc : pointer;

   // guard check: open guard, or reader and target in the same region
   assign in_read       = (state == ptr_pkg::ST_READ);
   assign target_region = region_of(mem_addr);
   assign allowed = guard_open(target_region, guard_lo, guard_hi)
                  | (target_region == exec_region);

   // byte lane within the 16-bit program word
   assign mem_byte = mem_addr[0] ? MEM_DATA[15:8] : MEM_DATA[7:0];

   // latch loads the memory byte, or a zero byte when the guard refuses
   assign next_latch = allowed ? mem_byte : ptr_pkg::REFUSED_BYTE;

   // register select
   assign sel_glo  = REG_ADDR == ptr_pkg::ADDR_GUARD_LO;
   assign sel_ghi  = REG_ADDR == ptr_pkg::ADDR_GUARD_HI;
   assign sel_pl   = REG_ADDR == ptr_pkg::ADDR_PTR_L;
   assign sel_ph   = REG_ADDR == ptr_pkg::ADDR_PTR_H;
   assign sel_pu   = REG_ADDR == ptr_pkg::ADDR_PTR_U;
   assign sel_lat  = REG_ADDR == ptr_pkg::ADDR_LATCH;
   assign sel_stat = REG_ADDR == ptr_pkg::ADDR_STATUS;
   assign wr_ptr   = REG_WR & (sel_pl | sel_ph | sel_pu);
   assign wr_glo   = REG_WR & sel_glo;
   assign wr_ghi   = REG_WR & sel_ghi;
   assign wr_lat   = REG_WR & sel_lat;

   // status clear and a refusal in the same cycle: the refusal is kept
   assign clr_refused = REG_WR & sel_stat & REG_WDATA[ptr_pkg::STAT_REFUSED];
   assign refuse_now  = in_read & ~allowed;

   // clear-only guard update, so software can never reopen a guard
   assign next_guard_lo = wr_glo ? guard_clear(guard_lo, REG_WDATA, ptr_pkg::GUARD_LO_MASK)
                                 : guard_lo;
   assign next_guard_hi = wr_ghi ? guard_clear(guard_hi, REG_WDATA, ptr_pkg::GUARD_HI_MASK)
                                 : guard_hi;

   // software read views; bits without a meaning always read zero
   assign guard_lo_view = guard_lo & ptr_pkg::GUARD_LO_MASK;
   assign guard_hi_view = guard_hi & ptr_pkg::GUARD_HI_MASK;
   assign ptr_u_view    = {3'h0, pointer[20:16]} & ptr_pkg::PTR_U_MASK;

   // software view of the pointer after a byte write
   assign sw_pointer = {
      sel_pu ? REG_WDATA[4:0] : pointer[20:16],
      sel_ph ? REG_WDATA      : pointer[15:8],
      sel_pl ? REG_WDATA      : pointer[7:0]
   };

   // next pointer: the completing read wins over a software write
   always_comb begin
      next_pointer = pointer;
      if (in_read) begin
         case (mode)
            ptr_pkg::MODE_KEEP:    next_pointer = pointer;
            ptr_pkg::MODE_POSTINC: next_pointer = ptr_inc;
            ptr_pkg::MODE_POSTDEC: next_pointer = ptr_dec;
            ptr_pkg::MODE_PREINC:  next_pointer = mem_addr;
            default:               next_pointer = pointer;
         endcase
      end else if (wr_ptr) begin
         next_pointer = sw_pointer;
      end
   end

   // sequencer: decode cycle then read cycle
   always_comb begin
      next_state = state;
      case (state)
         ptr_pkg::ST_IDLE: begin
            if (accept) begin
               next_state = ptr_pkg::ST_READ;
            end
         end
         ptr_pkg::ST_READ: next_state = ptr_pkg::ST_IDLE;
         default:          next_state = ptr_pkg::ST_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state <= ptr_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // table pointer; wraps inside its own width through next_pointer
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pointer <= ptr_pkg::PTR_RESET;
      end else begin
         pointer <= next_pointer;
      end
   end

   // array read strobe, high for exactly the read cycle
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mem_rd <= 1'b0;
      end else begin
         mem_rd <= accept;
      end
   end

   // capture mode, read address and issuing region at decode; they stand until the next accept
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mode        <= ptr_pkg::MODE_KEEP;
         mem_addr    <= ptr_pkg::PTR_RESET;
         exec_region <= ptr_pkg::BLK_NONE;
      end else if (accept) begin
         mode        <= instr_mode;
         mem_addr    <= target;
         exec_region <= region_of(INSTR_PC);
      end
   end

   // latch: the read cycle has priority over a software write
   always_ff @(posedge CLK) begin
      if (SRST) begin
         latch <= ptr_pkg::LATCH_RESET;
      end else if (in_read) begin
         latch <= next_latch;
      end else if (wr_lat) begin
         latch <= REG_WDATA;
      end
   end

   // completion pulse, one cycle after the read cycle
   always_ff @(posedge CLK) begin
      if (SRST) begin
         done <= 1'b0;
      end else begin
         done <= in_read;
      end
   end

   // refusal pulse, always together with the completion pulse
   always_ff @(posedge CLK) begin
      if (SRST) begin
         refused <= 1'b0;
      end else begin
         refused <= refuse_now;
      end
   end

   // sticky refusal flag, write one to clear; a new refusal beats the clear
   always_ff @(posedge CLK) begin
      if (SRST) begin
         refused_flag <= 1'b0;
      end else if (refuse_now) begin
         refused_flag <= 1'b1;
      end else if (clr_refused) begin
         refused_flag <= 1'b0;
      end
   end

   // guard bytes: unprogrammed ones after reset, clear-only writes otherwise
   always_ff @(posedge CLK) begin
      if (SRST) begin
         guard_lo <= ptr_pkg::GUARD_LO_RESET;
         guard_hi <= ptr_pkg::GUARD_HI_RESET;
      end else begin
         guard_lo <= next_guard_lo;
         guard_hi <= next_guard_hi;
      end
   end

   // status byte seen by software
   always_comb begin
      status_byte = 8'h00;
      status_byte[ptr_pkg::STAT_REFUSED] = refused_flag;
      status_byte[ptr_pkg::STAT_BUSY]    = in_read;
   end

   // read mux; unmapped addresses answer zero
   always_comb begin
      rd_mux = 8'h00;
      if (sel_glo) begin
         rd_mux = guard_lo_view;
      end else if (sel_ghi) begin
         rd_mux = guard_hi_view;
      end else if (sel_pl) begin
         rd_mux = pointer[7:0];
      end else if (sel_ph) begin
         rd_mux = pointer[15:8];
      end else if (sel_pu) begin
         rd_mux = ptr_u_view;
      end else if (sel_lat) begin
         rd_mux = latch;
      end else if (sel_stat) begin
         rd_mux = status_byte;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rdata <= 8'h00;
      end else if (REG_RD) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 8'h00;
      end
   end

   // outputs, all from flip-flops except the ready handshake
   assign TBL_DONE      = done;
   assign TBL_REFUSED   = refused;
   assign TABLE_LATCH   = latch;
   assign TABLE_POINTER = pointer;
   assign MEM_ADDR      = mem_addr;
   assign MEM_RD        = mem_rd;
   assign REG_RDATA     = rdata;

endmodule : ptr_table_read

/* test/ptr_mem_model.sv */
// program flash array model answering the table read unit
`timescale 1ns/1ns
module ptr_mem_model (
   // array request
   input  wire logic [ptr_pkg::PTR_W-1:0] mem_addr,
   input  wire logic                      mem_rd,
   // array word
   output logic [15:0]                    mem_data
);
   logic [15:0] word;
   // word content follows the address so either byte is predictable
   assign word     = {mem_addr[16:9] ^ 8'h5A, mem_addr[8:1]};
   // outside the read cycle the lines carry junk, never a stale word
   assign mem_data = mem_rd ? word : ~word;
endmodule : ptr_mem_model

/* test/ptr_table_read_asserts.sv */
// concurrent checks on the table read unit ports
`timescale 1ns/1ns
module ptr_table_read_asserts (
   // clock and reset
   input wire logic                      CLK,
   input wire logic                      SRST,
   // instruction issue and completion
   input wire logic                      INSTR_VALID,
   input wire logic [15:0]               INSTR_WORD,
   input wire logic                      INSTR_READY,
   input wire logic                      TBL_DONE,
   input wire logic                      TBL_REFUSED,
   input wire logic [7:0]                TABLE_LATCH,
   input wire logic [ptr_pkg::PTR_W-1:0] TABLE_POINTER,
   // array side
   input wire logic [ptr_pkg::PTR_W-1:0] MEM_ADDR,
   input wire logic                      MEM_RD,
   input wire logic [15:0]               MEM_DATA,
   // register port
   input wire logic [ptr_pkg::ADR_W-1:0] REG_ADDR,
   input wire logic                      REG_RD,
   input wire logic [7:0]                REG_RDATA
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   // accepted opcode and the byte the read address bit picks
   wire       acc      = INSTR_VALID && INSTR_READY && ((INSTR_WORD & ptr_pkg::OPC_MASK) == ptr_pkg::OPC_FIXED);
   wire [1:0] mode     = INSTR_WORD[1:0];
   wire [7:0] sel_byte = MEM_ADDR[0] ? MEM_DATA[15:8] : MEM_DATA[7:0];

   chk_accept_read: assert property (acc |=> MEM_RD) else $error("read cycle missing after accept");
   chk_ignore_word: assert property (!acc |=> !MEM_RD) else $error("read cycle without accept");
   chk_two_cycles: assert property (MEM_RD |-> !INSTR_READY ##1 (TBL_DONE && !MEM_RD)) else $error("bad completion");
   chk_keep_ptr: assert property (acc && mode == 2'h0 |-> ##2 TABLE_POINTER == $past(TABLE_POINTER, 2))
      else $error("pointer moved in keep mode");
   chk_post_inc: assert property (acc && mode == 2'h1 |=> MEM_ADDR == $past(TABLE_POINTER)
      ##1 TABLE_POINTER == $past(TABLE_POINTER, 2) + 21'h1) else $error("post increment wrong");
   chk_post_dec: assert property (acc && mode == 2'h2 |-> ##2
      TABLE_POINTER == $past(TABLE_POINTER, 2) - 21'h1) else $error("post decrement wrong");
   chk_pre_inc: assert property (acc && mode == 2'h3 |=> MEM_ADDR == $past(TABLE_POINTER) + 21'h1)
      else $error("pre increment address wrong");
   chk_latch_byte: assert property (MEM_RD |=> TBL_REFUSED || TABLE_LATCH == $past(sel_byte))
      else $error("latch byte wrong");
   chk_refused_zero: assert property (TBL_REFUSED |-> TBL_DONE && TABLE_LATCH == 8'h00)
      else $error("refused read leaked data");
   chk_guard_hi_bits: assert property (REG_RD && REG_ADDR == ptr_pkg::ADDR_GUARD_HI
      |=> (REG_RDATA & ~ptr_pkg::GUARD_HI_MASK) == 8'h00) else $error("unused high guard bits set");
   chk_guard_lo_bits: assert property (REG_RD && REG_ADDR == ptr_pkg::ADDR_GUARD_LO
      |=> REG_RDATA[7:6] == 2'h0) else $error("unused low guard bits set");
endmodule : ptr_table_read_asserts

bind ptr_table_read ptr_table_read_asserts i_ptr_table_read_asserts (.CLK, .SRST, .INSTR_VALID, .INSTR_WORD,
   .INSTR_READY, .TBL_DONE, .TBL_REFUSED, .TABLE_LATCH, .TABLE_POINTER, .MEM_ADDR, .MEM_RD, .MEM_DATA,
   .REG_ADDR, .REG_RD, .REG_RDATA);

/* test/ptr_table_read_tb.sv */
// self-checking bench for the table read unit
`timescale 1ns/1ns
module ptr_table_read_tb;
   logic        clk, srst, instr_valid, instr_ready, tbl_done, tbl_refused, mem_rd, reg_wr, reg_rd, refd;
   logic [15:0] instr_word, mem_data;
   logic [20:0] instr_pc, table_pointer, mem_addr;
   logic [21:0] reg_addr;
   logic [7:0]  table_latch, reg_wdata, reg_rdata;
   int          n_fail, checks;

   ptr_table_read i_ptr_table_read (.CLK(clk), .SRST(srst), .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
      .INSTR_PC(instr_pc), .INSTR_READY(instr_ready), .TBL_DONE(tbl_done), .TBL_REFUSED(tbl_refused),
      .TABLE_LATCH(table_latch), .TABLE_POINTER(table_pointer), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
      .MEM_DATA(mem_data), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata));
   ptr_mem_model i_ptr_mem_model (.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data));

   // 100 MHz clock
   always #5 clk = ~clk;

   task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task conclude;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // expected array byte, worked out independently of the model wiring
   function automatic logic [7:0] eb(input logic [20:0] a);
      return a[0] ? (a[16:9] ^ 8'h5A) : a[8:1];
   endfunction : eb

   task automatic reg_wr_t(input logic [21:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_wr_t

   // read data stands only in the cycle after the strobe
   task automatic reg_rd_t(input string nm, input logic [21:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      cmp(nm, e, reg_rdata);
   endtask : reg_rd_t

   task automatic set_ptr(input logic [20:0] p);
      reg_wr_t(ptr_pkg::ADDR_PTR_L, p[7:0]);
      reg_wr_t(ptr_pkg::ADDR_PTR_H, p[15:8]);
      reg_wr_t(ptr_pkg::ADDR_PTR_U, {3'h0, p[20:16]});
   endtask : set_ptr

   // issue one table read and wait a bounded time for completion
   task automatic tbl(input logic [1:0] m, input logic [20:0] pc);
      int k;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= ptr_pkg::OPC_FIXED | {14'h0, m};
      instr_pc    <= pc;
      @(posedge clk);
      instr_valid <= 1'b0;
      for (k = 0; k < 6 && tbl_done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      if (tbl_done !== 1'b1) begin
         n_fail++;
         $display("mismatch tbl_done expected 1 seen %b", tbl_done);
         conclude();
      end
      refd = tbl_refused;
   endtask : tbl

   task t_reset_regs;
      reg_rd_t("guard_lo", ptr_pkg::ADDR_GUARD_LO, 8'h3F);
      reg_rd_t("guard_hi", ptr_pkg::ADDR_GUARD_HI, 8'h40);
      reg_rd_t("unmapped", 22'h000100, 8'h00);
   endtask : t_reset_regs

   task t_decode;
      int k;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= 16'h000C;
      @(posedge clk);
      instr_valid <= 1'b0;
      for (k = 0; k < 3; k++) begin
         #1;
         cmp("ignored mem_rd", 24'h0, mem_rd);
         @(posedge clk);
      end
   endtask : t_decode

   // all four modes in a row from one start pointer, both bytes of a word
   task t_modes;
      logic [20:0] p, a;
      int m;
      p = 21'h00A356;
      set_ptr(p);
      for (m = 0; m < 4; m++) begin
         a = (m == 3) ? p + 21'h1 : p;
         tbl(m[1:0], 21'h000900);
         p = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
         cmp("latch", eb(a), table_latch);
         cmp("pointer", p, table_pointer);
      end
   endtask : t_modes

   task t_wrap;
      set_ptr(21'h1FFFFF);
      tbl(2'h1, 21'h000900);
      cmp("wrap up", 21'h000000, table_pointer);
      cmp("wrap latch", eb(21'h1FFFFF), table_latch);
      tbl(2'h2, 21'h000900);
      cmp("wrap down", 21'h1FFFFF, table_pointer);
      reg_rd_t("ptr upper", ptr_pkg::ADDR_PTR_U, 8'h1F);
   endtask : t_wrap

   // the larger variant has block 5, so its guard may be cleared
   task t_guard;
      reg_wr_t(ptr_pkg::ADDR_GUARD_LO, 8'hDF);
      reg_rd_t("guard_lo clr", ptr_pkg::ADDR_GUARD_LO, 8'h1F);
      reg_wr_t(ptr_pkg::ADDR_GUARD_LO, 8'hFF);
      reg_rd_t("guard_lo set", ptr_pkg::ADDR_GUARD_LO, 8'h1F);
      set_ptr(21'h017FFF);
      tbl(2'h0, 21'h000900);
      cmp("blk5 other", 24'h1, refd);
      cmp("blk5 latch", 24'h0, table_latch);
      tbl(2'h0, 21'h014002);
      cmp("blk5 inside", 24'h0, refd);
      cmp("blk5 in latch", eb(21'h017FFF), table_latch);
      set_ptr(21'h010000);
      tbl(2'h0, 21'h000900);
      cmp("blk4 open", 24'h0, refd);
      reg_wr_t(ptr_pkg::ADDR_GUARD_HI, 8'h00);
      reg_rd_t("guard_hi clr", ptr_pkg::ADDR_GUARD_HI, 8'h00);
      set_ptr(21'h0007FF);
      tbl(2'h0, 21'h000900);
      cmp("boot other", 24'h1, refd);
      tbl(2'h0, 21'h000100);
      cmp("boot inside", 24'h0, refd);
      reg_rd_t("status set", ptr_pkg::ADDR_STATUS, 8'h01);
      reg_wr_t(ptr_pkg::ADDR_STATUS, 8'h01);
      reg_rd_t("status clr", ptr_pkg::ADDR_STATUS, 8'h00);
   endtask : t_guard

   // a second reset in mid-run puts every guard back to unprogrammed
   task t_rereset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      cmp("ptr reset", 24'h0, table_pointer);
      t_reset_regs();
   endtask : t_rereset

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end

   initial begin
      {clk, instr_valid, reg_wr, reg_rd, refd} = '0;
      srst        = 1'b1;
      instr_word  = 16'h0000;
      instr_pc    = 21'h000000;
      reg_addr    = 22'h000000;
      reg_wdata   = 8'h00;
      n_fail      = 0;
      checks      = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset_regs();
      t_decode();
      t_modes();
      t_wrap();
      t_guard();
      t_rereset();
      conclude();
   end
endmodule : ptr_table_read_tb
